// [rtl/antenna_driver_level_regs.v]
// Antenna driver level, modulation depth result and field detector threshold registers
//
// Contract
// RQ1: Read-only depth result shows disabled modulated segments
// RQ2: Failed calibration loads result with all ones
// RQ3: Result clears at reset and set-default
// RQ4: Source bit one: mask disables modulated segments
// RQ5: Source bit selects calibrated or written level
// RQ6: Bit 7 is 2 ohm, bit 0 256 ohm
// RQ7: Normal mask disables segments when unmodulated
// RQ8: Normal mask all ones tristates drivers
// RQ9: Bits 6..4 select peer detection threshold
// RQ10: Bits 3..0 select collision avoidance threshold
// RQ11: Reset masks zero, thresholds peer 011 collision 0011
// RQ12: Stored values drive static control outputs
`timescale 1ns/100ps
`include "antenna_level_map.vh"
module antenna_driver_level_regs (
    input  wire                 core_clk,
    input  wire                 sys_rst,
    input  wire                 set_default,
    input  wire [`ADDR_W-1:0]   reg_addr,
    input  wire [`DATA_W-1:0]   reg_wdata,
    input  wire                 reg_wr,
    input  wire                 reg_rd,
    output wire [`DATA_W-1:0]   reg_rdata,
    input  wire                 cal_done,
    input  wire                 cal_fail,
    input  wire [`SEG_N-1:0]    cal_seg_pattern,
    input  wire                 tx_modulated,
    output wire [`SEG_N-1:0]    seg_disable,
    output wire                 driver_tristate,
    output wire                 am_level_source_sel,
    output wire [5:0]           calibrated_depth_code,
    output wire [`SEG_N-1:0]    modulated_seg_disable,
    output wire [`SEG_N-1:0]    normal_seg_disable,
    output wire [2:0]           peer_thresh_code,
    output wire [3:0]           collision_thresh_code,
    output wire [`MV_W-1:0]     peer_thresh_mv,
    output wire [`MV_W-1:0]     collision_thresh_mv
);
    reg  [`DATA_W-1:0] am_ctrl_q;
    reg  [`DATA_W-1:0] am_ctrl_d;
    reg  [`DATA_W-1:0] depth_res_q;
    reg  [`DATA_W-1:0] depth_res_d;
    reg  [`DATA_W-1:0] mod_mask_q;
    reg  [`DATA_W-1:0] mod_mask_d;
    reg  [`DATA_W-1:0] norm_mask_q;
    reg  [`DATA_W-1:0] norm_mask_d;
    reg  [`DATA_W-1:0] thresh_q;
    reg  [`DATA_W-1:0] thresh_d;
    reg  [`DATA_W-1:0] rdata_q;
    reg  [`DATA_W-1:0] rdata_d;
    reg  [`SEG_N-1:0]  mod_active_q;
    reg  [`SEG_N-1:0]  mod_active_d;
    reg                tristate_q;
    reg                tx_mod_q;
    wire               wr_am_ctrl;
    wire               wr_mod_mask;
    wire               wr_norm_mask;
    wire               wr_thresh;

    assign wr_am_ctrl   = reg_wr && (reg_addr == `ADDR_AM_DEPTH_CTRL);
    assign wr_mod_mask  = reg_wr && (reg_addr == `ADDR_MOD_SEG_MASK);
    assign wr_norm_mask = reg_wr && (reg_addr == `ADDR_NORM_SEG_MASK);
    assign wr_thresh    = reg_wr && (reg_addr == `ADDR_FIELD_THRESH);

    // Writable registers; set-default overrides a write in the same cycle
    always @* begin
        am_ctrl_d   = am_ctrl_q;
        mod_mask_d  = mod_mask_q;
        norm_mask_d = norm_mask_q;
        thresh_d    = thresh_q;
        if (set_default) begin
            // RQ11: default masks, thresholds
            am_ctrl_d   = `RST_AM_DEPTH_CTRL;
            mod_mask_d  = `RST_MOD_SEG_MASK;
            norm_mask_d = `RST_NORM_SEG_MASK;
            thresh_d    = `RST_FIELD_THRESH;
        end else begin
            if (wr_am_ctrl) begin
                am_ctrl_d = reg_wdata & `AM_CTRL_USED_MASK;
            end
            // RQ6: bit order kept
            if (wr_mod_mask) begin
                mod_mask_d = reg_wdata;
            end
            if (wr_norm_mask) begin
                norm_mask_d = reg_wdata;
            end
            // RQ11: bit 7 unused
            if (wr_thresh) begin
                thresh_d = reg_wdata & `THRESH_USED_MASK;
            end
        end
    end

    // Calibration result; software cannot write it
    always @* begin
        depth_res_d = depth_res_q;
        if (set_default) begin
            // RQ3: cleared by command
            depth_res_d = `RST_MOD_DEPTH_RES;
        end else if (cal_done) begin
            // RQ2: failure gives all ones
            depth_res_d = cal_fail ? `CAL_FAIL_PATTERN : cal_seg_pattern;
        end
    end

    // Pattern applied in the modulated state
    always @* begin
        // RQ5: source select
        if (am_ctrl_q[`AM_SRC_BIT]) begin
            // RQ4: written mask used
            mod_active_d = mod_mask_q;
        end else begin
            // RQ1: calibrated segments disabled
            mod_active_d = depth_res_q;
        end
    end

    // Read mux; unmapped addresses read zero, data only in the following cycle
    always @* begin
        rdata_d = `READ_IDLE;
        if (reg_rd) begin
            case (reg_addr)
                `ADDR_AM_DEPTH_CTRL: rdata_d = am_ctrl_q;
                // RQ1: result readable
                `ADDR_MOD_DEPTH_RES: rdata_d = depth_res_q;
                `ADDR_MOD_SEG_MASK:  rdata_d = mod_mask_q;
                `ADDR_NORM_SEG_MASK: rdata_d = norm_mask_q;
                `ADDR_FIELD_THRESH:  rdata_d = thresh_q;
                default:             rdata_d = `READ_IDLE;
            endcase
        end
    end

    always @(posedge core_clk) begin
        if (sys_rst) begin
            // RQ3: power-up clear
            depth_res_q  <= `RST_MOD_DEPTH_RES;
            // RQ11: power-up defaults
            am_ctrl_q    <= `RST_AM_DEPTH_CTRL;
            mod_mask_q   <= `RST_MOD_SEG_MASK;
            norm_mask_q  <= `RST_NORM_SEG_MASK;
            thresh_q     <= `RST_FIELD_THRESH;
            rdata_q      <= `READ_IDLE;
            mod_active_q <= `RST_MOD_SEG_MASK;
            tristate_q   <= 1'b0;
            tx_mod_q     <= 1'b0;
        end else begin
            depth_res_q  <= depth_res_d;
            am_ctrl_q    <= am_ctrl_d;
            mod_mask_q   <= mod_mask_d;
            norm_mask_q  <= norm_mask_d;
            thresh_q     <= thresh_d;
            rdata_q      <= rdata_d;
            mod_active_q <= mod_active_d;
            // RQ8: all ones tristates
            tristate_q   <= (norm_mask_q == `TRISTATE_PATTERN);
            // Delayed so state and selected pattern reach the mux together
            tx_mod_q     <= tx_modulated;
        end
    end

    // RQ7: normal pattern when unmodulated
    segment_drive u_segment_drive (
        .core_clk     (core_clk),
        .sys_rst      (sys_rst),
        .mod_pattern  (mod_active_q),
        .norm_pattern (norm_mask_q),
        .tx_modulated (tx_mod_q),
        .seg_disable  (seg_disable)
    );

    threshold_decode u_threshold_decode (
        .core_clk  (core_clk),
        .sys_rst   (sys_rst),
        .peer_code (thresh_q[`PEER_MSB:`PEER_LSB]),
        .coll_code (thresh_q[`COLL_MSB:`COLL_LSB]),
        .peer_mv   (peer_thresh_mv),
        .coll_mv   (collision_thresh_mv)
    );

    // RQ12: static control outputs
    assign reg_rdata             = rdata_q;
    assign driver_tristate       = tristate_q;
    assign am_level_source_sel   = am_ctrl_q[`AM_SRC_BIT];
    assign calibrated_depth_code = am_ctrl_q[`DEPTH_CODE_MSB:`DEPTH_CODE_LSB];
    assign modulated_seg_disable = mod_mask_q;
    assign normal_seg_disable    = norm_mask_q;
    // RQ9: peer code out
    assign peer_thresh_code      = thresh_q[`PEER_MSB:`PEER_LSB];
    // RQ10: collision code out
    assign collision_thresh_code = thresh_q[`COLL_MSB:`COLL_LSB];
endmodule // antenna_driver_level_regs

// [rtl/antenna_level_map.vh]
// Register map, field layout and reset values of the antenna driver level registers
`ifndef ANTENNA_LEVEL_MAP_VH
`define ANTENNA_LEVEL_MAP_VH

`define ADDR_W              8
`define DATA_W              8
`define SEG_N               8
`define MV_W                10

`define ADDR_AM_DEPTH_CTRL  8'h24
`define ADDR_MOD_DEPTH_RES  8'h25
`define ADDR_MOD_SEG_MASK   8'h26
`define ADDR_NORM_SEG_MASK  8'h27
`define ADDR_FIELD_THRESH   8'h29

`define RST_AM_DEPTH_CTRL   8'h00
`define RST_MOD_DEPTH_RES   8'h00
`define RST_MOD_SEG_MASK    8'h00
`define RST_NORM_SEG_MASK   8'h00
`define RST_FIELD_THRESH    8'h33
`define CAL_FAIL_PATTERN    8'hff
`define TRISTATE_PATTERN    8'hff
`define READ_IDLE           8'h00

`define AM_SRC_BIT          7
`define DEPTH_CODE_MSB      6
`define DEPTH_CODE_LSB      1
`define PEER_MSB            6
`define PEER_LSB            4
`define COLL_MSB            3
`define COLL_LSB            0
`define THRESH_USED_MASK    8'h7f
`define AM_CTRL_USED_MASK   8'hfe

`define MV_75               10'h04b
`define MV_105              10'h069
`define MV_150              10'h096
`define MV_205              10'h0cd
`define MV_290              10'h122
`define MV_400              10'h190
`define MV_560              10'h230
`define MV_800              10'h320
`define MV_25               10'h019
`define MV_33               10'h021
`define MV_47               10'h02f
`define MV_64               10'h040
`define MV_90               10'h05a
`define MV_125              10'h07d
`define MV_175              10'h0af
`define MV_250              10'h0fa

`endif

// [rtl/segment_drive.v]
// Per-segment disable pattern for the eight binary weighted driver segments
`timescale 1ns/100ps
`include "antenna_level_map.vh"
module segment_drive (
    input  wire                 core_clk,
    input  wire                 sys_rst,
    input  wire [`SEG_N-1:0]    mod_pattern,
    input  wire [`SEG_N-1:0]    norm_pattern,
    input  wire                 tx_modulated,
    output wire [`SEG_N-1:0]    seg_disable
);
    reg  [`SEG_N-1:0] seg_disable_q;
    genvar i;
    // Bit 7 is the strongest (lowest ohm) segment; reset leaves all enabled
    generate
        for (i = 0; i < `SEG_N; i = i + 1) begin : g_seg
            always @(posedge core_clk) begin
                if (sys_rst) begin
                    seg_disable_q[i] <= 1'b0;
                end else begin
                    seg_disable_q[i] <= tx_modulated ? mod_pattern[i] : norm_pattern[i];
                end
            end
        end
    endgenerate
    assign seg_disable = seg_disable_q;
endmodule // segment_drive

// [rtl/threshold_decode.v]
// Nominal millivolt figures of the field detector threshold codes
`timescale 1ns/100ps
`include "antenna_level_map.vh"
module threshold_decode (
    input  wire                 core_clk,
    input  wire                 sys_rst,
    input  wire [2:0]           peer_code,
    input  wire [3:0]           coll_code,
    output wire [`MV_W-1:0]     peer_mv,
    output wire [`MV_W-1:0]     coll_mv
);
    reg  [`MV_W-1:0] peer_mv_q;
    reg  [`MV_W-1:0] coll_mv_q;

    function [`MV_W-1:0] high_range;
        input [2:0] code;
        begin
            case (code)
                3'h0:    high_range = `MV_75;
                3'h1:    high_range = `MV_105;
                3'h2:    high_range = `MV_150;
                3'h3:    high_range = `MV_205;
                3'h4:    high_range = `MV_290;
                3'h5:    high_range = `MV_400;
                3'h6:    high_range = `MV_560;
                default: high_range = `MV_800;
            endcase
        end
    endfunction

    function [`MV_W-1:0] low_range;
        input [2:0] code;
        begin
            case (code)
                3'h0:    low_range = `MV_25;
                3'h1:    low_range = `MV_33;
                3'h2:    low_range = `MV_47;
                3'h3:    low_range = `MV_64;
                3'h4:    low_range = `MV_90;
                3'h5:    low_range = `MV_125;
                3'h6:    low_range = `MV_175;
                default: low_range = `MV_250;
            endcase
        end
    endfunction

    always @(posedge core_clk) begin
        if (sys_rst) begin
            peer_mv_q <= `MV_205;
            coll_mv_q <= `MV_205;
        end else begin
            // RQ9: peer 75..800 mV
            peer_mv_q <= high_range(peer_code);
            // RQ10: two collision ranges
            coll_mv_q <= coll_code[3] ? low_range(coll_code[2:0]) : high_range(coll_code[2:0]);
        end
    end

    assign peer_mv = peer_mv_q;
    assign coll_mv = coll_mv_q;
endmodule // threshold_decode

// [sim/level_regs_checker.sv]
// Port checks of the antenna driver level registers
`timescale 1ns/100ps
module level_regs_checker (
    input logic       core_clk,
    input logic       sys_rst,
    input logic       set_default,
    input logic [7:0] reg_addr,
    input logic [7:0] reg_wdata,
    input logic       reg_wr,
    input logic       reg_rd,
    input logic [7:0] reg_rdata,
    input logic       tx_modulated,
    input logic [7:0] seg_disable,
    input logic       driver_tristate,
    input logic       am_level_source_sel,
    input logic [7:0] modulated_seg_disable,
    input logic [7:0] normal_seg_disable,
    input logic [2:0] peer_thresh_code,
    input logic [3:0] collision_thresh_code,
    input logic [9:0] peer_thresh_mv,
    input logic [9:0] collision_thresh_mv
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    // A write beside set-default is lost, so only clean writes count
    wire wr_ok = reg_wr && !set_default;
    rd_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data not idle");
    rd_thresh_a: assert property (reg_rd && reg_addr == 8'h29
        |=> reg_rdata == {1'b0, $past(peer_thresh_code), $past(collision_thresh_code)})
        else $error("threshold read wrong");
    norm_wr_a: assert property (wr_ok && reg_addr == 8'h27
        |=> normal_seg_disable == $past(reg_wdata)) else $error("normal mask write lost");
    mod_wr_a: assert property (wr_ok && reg_addr == 8'h26
        |=> modulated_seg_disable == $past(reg_wdata)) else $error("modulated mask write lost");
    thr_wr_a: assert property (wr_ok && reg_addr == 8'h29
        |=> {1'b0, peer_thresh_code, collision_thresh_code} == ($past(reg_wdata) & 8'h7f))
        else $error("threshold write wrong");
    set_def_a: assert property (set_default |=> normal_seg_disable == 8'h00
        && modulated_seg_disable == 8'h00 && peer_thresh_code == 3'h3
        && collision_thresh_code == 4'h3) else $error("set-default values wrong");
    tristate_a: assert property (driver_tristate == ($past(normal_seg_disable) == 8'hff))
        else $error("tristate flag wrong");
    seg_norm_a: assert property (!$past(tx_modulated, 2)
        |-> seg_disable == $past(normal_seg_disable)) else $error("normal segments wrong");
    seg_mod_a: assert property ($past(tx_modulated, 2) && $past(am_level_source_sel, 2)
        |-> seg_disable == $past(modulated_seg_disable, 2)) else $error("modulated segs wrong");
    peer_mv_a: assert property ($past(peer_thresh_code) == 3'h7
        |-> peer_thresh_mv == 10'h320) else $error("peer top level wrong");
    coll_mv_a: assert property ($past(collision_thresh_code) == 4'h8
        |-> collision_thresh_mv == 10'h019) else $error("collision low range wrong");
    cover property ($rose(driver_tristate));
    cover property (tx_modulated && am_level_source_sel);
    cover property (set_default ##1 reg_rd);
endmodule // level_regs_checker
bind antenna_driver_level_regs level_regs_checker i_chk (.*);

// [sim/tb_top.sv]
// Self-checking bench of the antenna driver level registers
`timescale 1ns/100ps
module tb_top;
    logic       core_clk = 1'b0, sys_rst = 1'b1, set_default = 1'b0, reg_wr = 1'b0;
    logic       reg_rd = 1'b0, cal_done = 1'b0, cal_fail = 1'b0, tx_modulated = 1'b0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, cal_seg_pattern = 8'h00;
    wire  [7:0] reg_rdata, seg_disable, modulated_seg_disable, normal_seg_disable;
    wire        driver_tristate, am_level_source_sel;
    wire  [5:0] calibrated_depth_code;
    wire  [2:0] peer_thresh_code;
    wire  [3:0] collision_thresh_code;
    wire  [9:0] peer_thresh_mv, collision_thresh_mv;
    int         bad_count = 0, check_count = 0;
    logic [31:0] lfsr_q = 32'hd94c;
    logic [7:0] m [int];
    int         mvp [8] = '{75, 105, 150, 205, 290, 400, 560, 800};
    int mvc [16] = '{75, 105, 150, 205, 290, 400, 560, 800, 25, 33, 47, 64, 90, 125, 175, 250};
    always #10 core_clk = ~core_clk;
    antenna_driver_level_regs i_dut (.core_clk(core_clk), .sys_rst(sys_rst),
        .set_default(set_default), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cal_done(cal_done),
        .cal_fail(cal_fail), .cal_seg_pattern(cal_seg_pattern), .tx_modulated(tx_modulated),
        .seg_disable(seg_disable), .driver_tristate(driver_tristate),
        .am_level_source_sel(am_level_source_sel), .calibrated_depth_code(calibrated_depth_code),
        .modulated_seg_disable(modulated_seg_disable), .normal_seg_disable(normal_seg_disable),
        .peer_thresh_code(peer_thresh_code), .collision_thresh_code(collision_thresh_code),
        .peer_thresh_mv(peer_thresh_mv), .collision_thresh_mv(collision_thresh_mv));
    task automatic print_verdict;
        if (bad_count == 0 && check_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input string n, input logic [9:0] e, input logic [9:0] s);
        check_count++;
        if (s !== e) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", n, e, s);
        end
    endtask
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic dflt;
        m[8'h24] = 8'h00; m[8'h25] = 8'h00; m[8'h26] = 8'h00; m[8'h27] = 8'h00;
        m[8'h29] = 8'h33;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        // Read-only and unmapped places keep their content
        if (m.exists(a) && a != 8'h25) m[a] = d & (a == 8'h24 ? 8'hfe : a == 8'h29 ? 8'h7f : 8'hff);
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 chk("reg_rdata", 10'(m.exists(a) ? m[a] : 8'h00), 10'(reg_rdata));
    endtask
    task automatic cal(input logic f, input logic [7:0] p);
        @(posedge core_clk);
        cal_done <= 1'b1;
        cal_fail <= f;
        cal_seg_pattern <= p;
        @(posedge core_clk);
        cal_done <= 1'b0;
        m[8'h25] = f ? 8'hff : p;
    endtask
    task automatic chk_outs;
        logic [7:0] seg;
        repeat (4) @(posedge core_clk);
        #1 seg = tx_modulated ? (m[8'h24][7] ? m[8'h26] : m[8'h25]) : m[8'h27];
        chk("seg_disable", 10'(seg), 10'(seg_disable));
        chk("tristate", 10'(m[8'h27] == 8'hff), 10'(driver_tristate));
        chk("normal_mask", 10'(m[8'h27]), 10'(normal_seg_disable));
        chk("mod_mask", 10'(m[8'h26]), 10'(modulated_seg_disable));
        chk("src_sel", 10'(m[8'h24][7]), 10'(am_level_source_sel));
        chk("depth_code", 10'(m[8'h24][6:1]), 10'(calibrated_depth_code));
        chk("peer_code", 10'(m[8'h29][6:4]), 10'(peer_thresh_code));
        chk("coll_code", 10'(m[8'h29][3:0]), 10'(collision_thresh_code));
        chk("peer_mv", 10'(mvp[m[8'h29][6:4]]), peer_thresh_mv);
        chk("coll_mv", 10'(mvc[m[8'h29][3:0]]), collision_thresh_mv);
    endtask
    initial begin
        dflt();
        repeat (12) @(posedge core_clk);
        sys_rst <= 1'b0;
        for (int a = 8'h24; a < 8'h2b; a++) rd(8'(a));
        chk_outs();
        for (int i = 0; i < 36; i++) begin
            lfsr_q = lfsr_next(lfsr_q);
            wr(8'h24 + 8'(i % 6), lfsr_q[7:0]);
            rd(8'h24 + 8'(i % 6));
        end
        chk_outs();
        for (int i = 0; i < 16; i++) begin
            wr(8'h29, 8'((i % 8) * 16 + i));
            chk_outs();
        end
        wr(8'h27, 8'hff);
        chk_outs();
        wr(8'h27, 8'hc0);
        chk_outs();
        @(posedge core_clk) tx_modulated <= 1'b1;
        wr(8'h24, 8'h7e);
        cal(1'b1, lfsr_q[15:8]);
        chk_outs();
        rd(8'h25);
        cal(1'b0, lfsr_q[23:16]);
        chk_outs();
        wr(8'h24, 8'h80);
        wr(8'h26, lfsr_q[31:24]);
        chk_outs();
        // Write beside the command is lost
        @(posedge core_clk);
        tx_modulated <= 1'b0;
        set_default <= 1'b1;
        reg_wr <= 1'b1;
        reg_addr <= 8'h27;
        reg_wdata <= 8'h55;
        @(posedge core_clk);
        set_default <= 1'b0;
        reg_wr <= 1'b0;
        dflt();
        for (int a = 8'h24; a < 8'h2a; a++) rd(8'(a));
        chk_outs();
        print_verdict();
    end
    initial begin
        #200000;
        bad_count++;
        print_verdict();
    end
endmodule // tb_top
